// ### pkg/anpd_cfg.svh
// Constants of the negotiation arbiter: offsets, fields, resets, timing.
// Assumes inclusion by bare name; definitions only.
`ifndef ANPD_CFG_SVH
`define ANPD_CFG_SVH
// Register indices; byte address is four times the index
`define ANPD_IDX_CTRL   6'h00
`define ANPD_IDX_STAT   6'h01
`define ANPD_IDX_ADV    6'h04
`define ANPD_IDX_LPA    6'h05
`define ANPD_IDX_EXP    6'h06
`define ANPD_IDX_QP     6'h11
// Control fields
`define ANPD_CTRL_RESTART 9
`define ANPD_CTRL_AN_EN   12
`define ANPD_CTRL_RST     16'h1000
// Status fields
`define ANPD_STAT_DONE  5
`define ANPD_EXP_CAP    0
`define ANPD_EXP_PDF    4
`define ANPD_QP_RATE    15
`define ANPD_QP_DPX     14
`define ANPD_QP_DONE    4
`define ANPD_QP_NOSIG   3
// Ability fields
`define ANPD_AB_10H     5
`define ANPD_AB_10F     6
`define ANPD_AB_100H    7
`define ANPD_AB_100F    8
`define ANPD_AB_T4      9
`define ANPD_ADV_RST    16'h01e1
// Timing
`define ANPD_CLK_MHZ    100
`define ANPD_RESP_US    10
`define ANPD_RESP_CYC   (`ANPD_RESP_US * `ANPD_CLK_MHZ)
`define ANPD_HALF_100   2
`define ANPD_HALF_10    20
`endif

// ### pkg/anpd_pkg.sv
// Types of the negotiation arbiter.
// Assumes the constants header is compiled alongside.
package anpd_pkg;
  // Arbitration states
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEND, ST_DONE, ST_FAULT
  } anpd_state_t;
  // Resolved technology
  typedef enum logic [2:0] {
    TECH_NONE, TECH_10H, TECH_10F, TECH_100H, TECH_100F
  } anpd_tech_t;
endpackage

// ### rtl/anpd_top.sv
// Negotiation arbiter with priority resolution and parallel detection.
// Assumes line receiver indications arrive asynchronously on pins,
// and an Avalon-MM master on the 100 MHz clock.
//
// Overview of operation
// - Burst content comes from local advertisement
// - Received partner word stored in ability register
// - Send bursts, not normal pulses, while negotiating
// - Full negotiation only when both sides enabled
// - Pick highest common technology by ranking
// - Never resolve four-pair; fall through lower
// - Completion sets status and mirror bits
// - Enable chosen technology, power down others
// - No burst reply: parallel detect, clear capable
// - Parallel detect sets detected ability bit
// - Parallel detect completion sets complete bit
// - Only normal pulses: select 10M
// - Scrambled idles: select 100M
// - Burst reply sets partner capable bit
// - No signal sets signal-absent bit
// - Several indications: fault, nothing enabled
// - Parallel detect runs without management
// - MII clock 25 MHz or 2.5 MHz
// - Restart bit returns arbiter to idle
//
// Chosen here: register access over Avalon-MM and the register offsets.
`include "anpd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module anpd_top #(
  parameter int RESP_WAIT = `ANPD_RESP_CYC  // Burst reply wait, cycles
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output var  logic [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              rx_flp_valid,
  input  wire logic [15:0]       rx_flp_word,
  input  wire logic              rx_nlp_seen,
  input  wire logic              rx_idle100_seen,
  output var  logic [15:0]       tx_flp_word,
  output var  logic              tx_flp_en,
  output var  logic              tx_nlp_en,
  output var  logic              en_100,
  output var  logic              en_10,
  output var  logic              full_duplex,
  output var  logic              mii_clk,
  output var  anpd_pkg::anpd_tech_t tech
);
  import anpd_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [18:0] sync_a;        // First stage, read by sync_b only
  logic [18:0] sync_b;        // Second stage
  logic        flp_prev;      // Valid delayed for edge
  logic        flp_pulse;     // New partner word
  logic [15:0] lp_word_s;     // Synchronised partner word
  logic        nlp_s;         // Normal pulses present
  logic        idle_s;        // Scrambled idles present

  // Two flops on every pin input
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_a <= 19'h00000;
      sync_b <= 19'h00000;
    end else begin
      sync_a <= {rx_idle100_seen, rx_nlp_seen, rx_flp_valid,
                 rx_flp_word};
      sync_b <= sync_a;
    end
  end

  // Edge detect after the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flp_prev <= 1'b0;
    end else begin
      flp_prev <= sync_b[16];
    end
  end

  assign lp_word_s = sync_b[15:0];
  assign flp_pulse = sync_b[16] & ~flp_prev;
  assign nlp_s     = sync_b[17];
  assign idle_s    = sync_b[18];

  ////////////////////////////////////////////////////////////////
  // Bus slave

  logic        served;        // Second cycle of an access
  logic [5:0]  idx;           // Register index
  logic        wr_go;         // Write commits this edge
  logic [15:0] ctrl;          // Control register
  logic [15:0] adv;           // Local advertisement
  logic [15:0] lpa;           // Partner ability
  logic        done;          // Negotiation complete
  logic        lp_cap;        // Partner can negotiate
  logic        pd_fault;      // Parallel detection fault
  logic        no_sig;        // No signal on receive
  logic        restart;       // Restart strobe
  logic [15:0] wmask;         // Byte lane mask
  logic [15:0] rd_val;        // Read mux

  assign idx   = avs_address[7:2];
  assign wr_go = avs_write & served;
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // One wait state for every access
  assign avs_waitrequest = (avs_read | avs_write) & ~served;

  // Access phase tracker
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      served <= 1'b0;
    end else begin
      served <= (avs_read | avs_write) & ~served;
    end
  end

  // Read mux, unmapped reads give zero
  always_comb begin
    rd_val = 16'h0000;
    unique case (idx)
      `ANPD_IDX_CTRL: rd_val = ctrl;
      `ANPD_IDX_STAT: rd_val[`ANPD_STAT_DONE] = done;
      `ANPD_IDX_ADV:  rd_val = adv;
      `ANPD_IDX_LPA:  rd_val = lpa;
      `ANPD_IDX_EXP: begin
        rd_val[`ANPD_EXP_CAP] = lp_cap;
        rd_val[`ANPD_EXP_PDF] = pd_fault;
      end
      `ANPD_IDX_QP: begin
        rd_val[`ANPD_QP_RATE]  = en_100;
        rd_val[`ANPD_QP_DPX]   = full_duplex;
        rd_val[`ANPD_QP_DONE]  = done;
        rd_val[`ANPD_QP_NOSIG] = no_sig;
      end
      default: rd_val = 16'h0000;
    endcase
  end

  // Read data loaded in the wait cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~served) begin
      avs_readdata <= {16'h0000, rd_val};
    end
  end

  // Control register; restart bit self-clears
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= `ANPD_CTRL_RST;
    end else if (wr_go && idx == `ANPD_IDX_CTRL) begin
      ctrl <= (ctrl & ~wmask) | (avs_writedata[15:0] & wmask);
      ctrl[`ANPD_CTRL_RESTART] <= 1'b0;
    end
  end

  // Restart strobe from a written one
  assign restart = wr_go && idx == `ANPD_IDX_CTRL &&
                   avs_byteenable[1] &&
                   avs_writedata[`ANPD_CTRL_RESTART];

  // Advertisement register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      adv <= `ANPD_ADV_RST;
    end else if (wr_go && idx == `ANPD_IDX_ADV) begin
      adv <= (adv & ~wmask) | (avs_writedata[15:0] & wmask);
    end
  end

  // Burst content follows advertisement
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_flp_word <= `ANPD_ADV_RST;
    end else begin
      tx_flp_word <= adv;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Priority resolution

  logic [15:0] common;        // Shared abilities
  anpd_tech_t  pick;          // Best common technology

  // AND then fixed priority; four-pair skipped
  always_comb begin
    common = adv & lp_word_s;
    pick   = TECH_NONE;
    if (common[`ANPD_AB_100F]) begin
      pick = TECH_100F;
    end else if (common[`ANPD_AB_100H]) begin
      pick = TECH_100H;
    end else if (common[`ANPD_AB_10F]) begin
      pick = TECH_10F;
    end else if (common[`ANPD_AB_10H]) begin
      pick = TECH_10H;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Arbitration state machine

  anpd_state_t state;         // Present state
  logic [15:0] wait_cnt;      // Reply wait counter
  logic        an_en;         // Negotiation enabled
  logic        timeout;       // No burst reply in time
  logic        multi;         // Several indications

  assign an_en   = ctrl[`ANPD_CTRL_AN_EN];
  assign timeout = wait_cnt == 16'(RESP_WAIT - 1);
  assign multi   = nlp_s & idle_s;

  // State and technology
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      tech  <= TECH_NONE;
    end else if (restart || !an_en) begin
      state <= ST_IDLE;
      tech  <= TECH_NONE;
    end else begin
      unique case (state)
        // Start sending bursts
        ST_IDLE: begin
          state <= ST_SEND;
        end
        // Await a reply
        ST_SEND: begin
          if (flp_pulse) begin
            state <= ST_DONE;
            tech  <= pick;
          end else if (timeout) begin
            if (multi) begin
              state <= ST_FAULT;
            end else if (idle_s) begin
              state <= ST_DONE;
              tech  <= TECH_100H;
            end else if (nlp_s) begin
              state <= ST_DONE;
              tech  <= TECH_10H;
            end
          end
        end
        // Hold the result
        ST_DONE: begin
          state <= ST_DONE;
        end
        // Hold the fault until restart
        ST_FAULT: begin
          state <= ST_FAULT;
        end
      endcase
    end
  end

  // Reply wait counter, wraps to retry
  always_ff @(posedge clk) begin
    if (!rst_n || state != ST_SEND || timeout) begin
      wait_cnt <= 16'h0000;
    end else begin
      wait_cnt <= wait_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Status bits

  logic pd_done;              // Parallel detection resolves
  assign pd_done = state == ST_SEND && !flp_pulse && timeout &&
                   !multi && (nlp_s || idle_s);

  // Partner ability register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lpa <= 16'h0000;
    end else if (state == ST_SEND && flp_pulse) begin
      lpa <= lp_word_s;
    end else if (pd_done) begin
      lpa <= 16'h0000;
      lpa[`ANPD_AB_100H] <= idle_s;
      lpa[`ANPD_AB_10H]  <= nlp_s;
    end
  end

  // Complete, capable and fault flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done     <= 1'b0;
      lp_cap   <= 1'b0;
      pd_fault <= 1'b0;
    end else if (state == ST_SEND && flp_pulse && an_en) begin
      done   <= 1'b1;
      lp_cap <= 1'b1;
    end else if (pd_done && an_en) begin
      done   <= 1'b1;
      lp_cap <= 1'b0;
    end else if (state == ST_SEND && timeout && multi) begin
      pd_fault <= 1'b1;
      lp_cap   <= 1'b0;
    end else if (restart || !an_en) begin
      done <= 1'b0;
    end
  end

  // Signal absence flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      no_sig <= 1'b0;
    end else if (flp_pulse || nlp_s || idle_s) begin
      no_sig <= 1'b0;
    end else if (state == ST_SEND && timeout) begin
      no_sig <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Technology enables and link pulses

  // Chosen modules on, the rest powered down
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_100      <= 1'b0;
      en_10       <= 1'b0;
      full_duplex <= 1'b0;
      tx_flp_en   <= 1'b0;
      tx_nlp_en   <= 1'b0;
    end else begin
      en_100      <= tech == TECH_100F || tech == TECH_100H;
      en_10       <= tech == TECH_10F || tech == TECH_10H;
      full_duplex <= tech == TECH_100F || tech == TECH_10F;
      tx_flp_en   <= an_en && state == ST_SEND;
      tx_nlp_en   <= !an_en || state == ST_DONE;
    end
  end

  ////////////////////////////////////////////////////////////////
  // MII clock divider

  logic [4:0] div_cnt;        // Half period counter
  logic [4:0] half;           // Half period length
  assign half = en_100 ? 5'(`ANPD_HALF_100) : 5'(`ANPD_HALF_10);

  // Toggle at each half period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt <= 5'h00;
      mii_clk <= 1'b0;
    end else if (div_cnt >= half - 5'h01) begin
      div_cnt <= 5'h00;
      mii_clk <= ~mii_clk;
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks

  sequence s_adv_write;
    wr_go && idx == `ANPD_IDX_ADV && avs_byteenable == 4'hf;
  endsequence

  AST_ADV_TX: assert property (@(posedge clk) disable iff (!rst_n)
    s_adv_write |=> ##1 tx_flp_word == $past(avs_writedata[15:0], 2))
    else $error("burst word does not follow advertisement");

  AST_LPA_STORE: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_SEND && flp_pulse && an_en && !restart
    |=> lpa == $past(lp_word_s) && lp_cap && done)
    else $error("partner word not stored");

  AST_FLP_SEND: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_SEND && an_en |=> tx_flp_en && !tx_nlp_en)
    else $error("bursts not sent while negotiating");

  AST_NO_T4: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_SEND && flp_pulse && common[`ANPD_AB_T4] &&
    !common[`ANPD_AB_100F] && common[`ANPD_AB_100H] && an_en && !restart
    |=> tech == TECH_100H)
    else $error("four-pair not skipped");

  AST_ENABLE: assert property (@(posedge clk) disable iff (!rst_n)
    tech == TECH_10H ##1 tech == TECH_10H |-> en_10 && !en_100)
    else $error("wrong modules enabled");

  AST_PD_10: assert property (@(posedge clk) disable iff (!rst_n)
    pd_done && nlp_s && an_en && !restart
    |=> tech == TECH_10H && lpa[`ANPD_AB_10H] && done && !lp_cap)
    else $error("normal pulses not detected as 10M");

  AST_PD_100: assert property (@(posedge clk) disable iff (!rst_n)
    pd_done && idle_s && an_en && !restart
    |=> tech == TECH_100H && lpa[`ANPD_AB_100H] && done)
    else $error("idles not detected as 100M");

  AST_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_FAULT |-> tech == TECH_NONE ##1 !en_100 && !en_10)
    else $error("technology enabled under fault");

  AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
    restart |=> state == ST_IDLE && (!done || $past(state) == ST_SEND))
    else $error("restart did not reach idle");

  sequence s_mii_edge;
    $changed(mii_clk);
  endsequence

  AST_MII_100: assert property (@(posedge clk) disable iff (!rst_n)
    (en_100 && $stable(en_100)) and s_mii_edge
    |=> $stable(mii_clk) ##1 $changed(mii_clk))
    else $error("MII clock not 25 MHz");

  AST_RESET: assert property (@(posedge clk)
    !rst_n |=> !done && !lp_cap && !pd_fault && lpa == 16'h0000)
    else $error("status not cleared by reset");

endmodule

`default_nettype wire

// ### sim/anpd_partner.sv
// Remote link partner seen across the pair, reduced to line indications.
// Assumes the arbiter's clock; the bench commands which reply it gives.
`timescale 1ns/1ps
`default_nettype none

module anpd_partner (
  input  wire logic        clk,
  input  wire logic [2:0]  mode,         // 0 silent, 1 bursts, 2 pulses, 3 idles, 4 both
  input  wire logic [3:0]  delay,        // Extra cycles before the word is flagged
  input  wire logic [15:0] ability,      // Our own ability word
  input  wire logic        tx_flp_en,    // Device is sending bursts
  input  wire logic [15:0] tx_flp_word,  // Device burst content
  output var  logic        flp_valid,
  output var  logic [15:0] flp_word,
  output var  logic        nlp_seen,
  output var  logic        idle100_seen,
  output var  logic [15:0] heard_word    // Last word heard from the device
);
  logic [4:0] cnt = 5'h00;  // Cycles since bursts started

  initial flp_valid = 1'b0;
  initial flp_word = 16'h0000;
  initial heard_word = 16'h0000;

  //////////////////////////////////////////////////////////////////////////
  // Burst reply: only when we negotiate and the device is sending
  always @(posedge clk) begin
    if (mode == 3'h1 && tx_flp_en) begin
      if (cnt != 5'h1f)
        cnt <= cnt + 5'h01;
      if (cnt == 5'h01)
        flp_word <= ability;  // Word settles well before the flag
      if (cnt == 5'h04 + {1'b0, delay})
        flp_valid <= 1'b1;
    end else begin
      cnt <= 5'h00;
      flp_valid <= 1'b0;
      flp_word <= ~flp_word;  // Released word never holds a value
    end
  end

  // Legacy indications and what the device advertised
  always @(posedge clk) begin
    nlp_seen <= (mode == 3'h2) || (mode == 3'h4);
    idle100_seen <= (mode == 3'h3) || (mode == 3'h4);
    if (tx_flp_en)
      heard_word <= tx_flp_word;
  end
endmodule

`default_nettype wire

// ### sim/anpd_top_tb.sv
// Self-checking bench of the negotiation arbiter with a partner model.
// Assumes the constants header and type package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "anpd_cfg.svh"

module anpd_top_tb;
  import anpd_pkg::*;
  localparam int RW = 16;  // Shortened reply wait
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        flp_v, nlp, idl, tx_flp_en, tx_nlp_en, en_100, en_10, full_duplex, mii_clk;
  logic [15:0] flp_w, tx_flp_word, heard, rdv;
  anpd_tech_t  tech;
  logic [2:0]  p_mode = 3'h0;
  logic [3:0]  p_delay = 4'h0;
  logic [15:0] p_ab = 16'h0;
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;

  anpd_top #(.RESP_WAIT(RW)) anpd_top_i (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_flp_valid(flp_v), .rx_flp_word(flp_w), .rx_nlp_seen(nlp),
    .rx_idle100_seen(idl), .tx_flp_word(tx_flp_word), .tx_flp_en(tx_flp_en),
    .tx_nlp_en(tx_nlp_en), .en_100(en_100), .en_10(en_10),
    .full_duplex(full_duplex), .mii_clk(mii_clk), .tech(tech));

  anpd_partner anpd_partner_i (.clk(clk), .mode(p_mode), .delay(p_delay),
    .ability(p_ab), .tx_flp_en(tx_flp_en), .tx_flp_word(tx_flp_word),
    .flp_valid(flp_v), .flp_word(flp_w), .nlp_seen(nlp), .idle100_seen(idl),
    .heard_word(heard));

  //////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Compare, report, finish
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One bus access; held until waitrequest is seen low
  task automatic acc(input logic w, input logic [5:0] idx, input logic [15:0] wd,
                     input logic [3:0] be);
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {16'h0000, wd};
    avs_byteenable <= be;
    avs_read <= ~w;
    avs_write <= w;
    // Request stands until waitrequest is sampled low at a rising edge
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx);
    acc(1'b0, idx, 16'h0000, 4'hf);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    acc(1'b1, idx, d, 4'hf);
  endtask

  // Poll the status word until completion shows
  task automatic wait_done();
    int k;
    rdv = 16'h0000;
    for (k = 0; k < 200 && rdv[`ANPD_STAT_DONE] !== 1'b1; k++)
      rd(`ANPD_IDX_STAT);
    chk("done", rdv[`ANPD_STAT_DONE], 1'b1);
  endtask

  // Clock cycles between two changes of the nibble clock
  task automatic half_per(output int n);
    logic m;
    n = 0;
    @(negedge clk);
    m = mii_clk;
    while (mii_clk === m && n < 64) begin
      @(negedge clk);
      n++;
    end
    m = mii_clk;
    n = 0;
    while (mii_clk === m && n < 64) begin
      @(negedge clk);
      n++;
    end
  endtask

  // Highest common technology, four-pair skipped
  function automatic anpd_tech_t exp_tech(input logic [15:0] a, input logic [15:0] p);
    logic [15:0] c;
    c = a & p;
    if (c[`ANPD_AB_100F]) return TECH_100F;
    if (c[`ANPD_AB_100H]) return TECH_100H;
    if (c[`ANPD_AB_10F]) return TECH_10F;
    if (c[`ANPD_AB_10H]) return TECH_10H;
    return TECH_NONE;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [15:0] a, p;
    anpd_tech_t  t;
    int          n, i;
    n = $urandom(32'h11c86324);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and refused accesses
    rd(`ANPD_IDX_CTRL); chk("ctrl", rdv, 16'h1000);
    rd(`ANPD_IDX_ADV);  chk("adv", rdv, 16'h01e1);
    rd(`ANPD_IDX_LPA);  chk("lpa", rdv, 16'h0000);
    rd(`ANPD_IDX_EXP);  chk("exp", rdv, 16'h0000);
    chk("flp_en", tx_flp_en, 1'b1);
    chk("flp_word", tx_flp_word, 16'h01e1);
    wr(`ANPD_IDX_LPA, 16'hffff);
    rd(`ANPD_IDX_LPA);  chk("lpa ro", rdv, 16'h0000);
    rd(6'h3f);          chk("unmapped", rdv, 16'h0000);
    // Silent line, then several indications at once
    repeat (3 * RW) @(posedge clk);
    rd(`ANPD_IDX_QP);   chk("nosig", rdv[`ANPD_QP_NOSIG], 1'b1);
    chk("qp done", rdv[`ANPD_QP_DONE], 1'b0);
    p_mode <= 3'h4;
    repeat (3 * RW) @(posedge clk);
    rd(`ANPD_IDX_EXP);  chk("pdf", rdv[`ANPD_EXP_PDF], 1'b1);
    chk("no tech", {en_100, en_10}, 2'b00);
    // Full negotiations, corner words first, then random
    for (i = 0; i < 12; i++) begin
      a = {6'h00, 5'($urandom), 5'h01};
      p = 16'($urandom);
      if (i == 0) begin
        a = 16'h03e1;
        p = 16'h0221;
      end
      if (i == 1) begin
        a = 16'h03e1;
        p = 16'h0281;
      end
      if ((a & p & 16'h03e0) == 16'h0000) begin
        a[`ANPD_AB_10H] = 1'b1;
        p[`ANPD_AB_10H] = 1'b1;
      end
      t = exp_tech(a, p);
      p_mode <= 3'h1;
      p_ab <= p;
      p_delay <= 4'($urandom);
      wr(`ANPD_IDX_ADV, a);
      @(posedge clk);
      @(negedge clk);
      chk("flp_word", tx_flp_word, a);
      wr(`ANPD_IDX_CTRL, 16'h1200);
      wait_done();
      chk("heard", heard, a);
      rd(`ANPD_IDX_LPA);  chk("lpa", rdv, p);
      rd(`ANPD_IDX_EXP);  chk("cap", rdv[`ANPD_EXP_CAP], 1'b1);
      rd(`ANPD_IDX_QP);   chk("qp done", rdv[`ANPD_QP_DONE], 1'b1);
      chk("qp rate", rdv[`ANPD_QP_RATE], t inside {TECH_100F, TECH_100H});
      chk("qp dpx", rdv[`ANPD_QP_DPX], t inside {TECH_100F, TECH_10F});
      chk("tech", tech, t);
      chk("en_100", en_100, t inside {TECH_100F, TECH_100H});
      chk("en_10", en_10, t inside {TECH_10F, TECH_10H});
      chk("dpx", full_duplex, t inside {TECH_100F, TECH_10F});
      half_per(n);
      chk("mii half", n, (t inside {TECH_100F, TECH_100H}) ? `ANPD_HALF_100 : `ANPD_HALF_10);
    end
    // Legacy pulses after reset alone, no management action
    @(posedge clk);
    p_mode <= 3'h2;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ANPD_IDX_EXP);  chk("exp rst", rdv, 16'h0000);
    wait_done();
    rd(`ANPD_IDX_EXP);  chk("cap pd", rdv[`ANPD_EXP_CAP], 1'b0);
    rd(`ANPD_IDX_LPA);  chk("lpa 10h", rdv[`ANPD_AB_10H], 1'b1);
    chk("tech 10", tech, TECH_10H);
    chk("en_10 pd", en_10, 1'b1);
    // Scrambled idles after a restart
    p_mode <= 3'h3;
    wr(`ANPD_IDX_CTRL, 16'h1200);
    wait_done();
    rd(`ANPD_IDX_LPA);  chk("lpa 100h", rdv[`ANPD_AB_100H], 1'b1);
    chk("tech 100", tech, TECH_100H);
    chk("en_100 pd", {en_100, en_10}, 2'b10);
    // Disabled negotiation, then enable through the upper lane only
    p_mode <= 3'h1;
    wr(`ANPD_IDX_CTRL, 16'h0000);
    repeat (4) @(posedge clk);
    chk("flp off", {tx_flp_en, tx_nlp_en}, 2'b01);
    rd(`ANPD_IDX_STAT); chk("done off", rdv[`ANPD_STAT_DONE], 1'b0);
    acc(1'b1, `ANPD_IDX_CTRL, 16'h10ff, 4'h2);
    rd(`ANPD_IDX_CTRL); chk("ctrl be", rdv, 16'h1000);
    wait_done();
    chk("tech again", tech, exp_tech(a, p_ab));
    end_sim();
  end
endmodule

`default_nettype wire
